// [hw/kid_cfg.svh]
// Timing counts and field positions for the key ID download block.
// Assumes the core clock runs at KID_CLK_HZ; included by bare name.
`ifndef KID_CFG_SVH
`define KID_CFG_SVH
`define KID_CLK_HZ        50000000
`define KID_SYNC_MS       100
`define KID_STROBE_MS     100
`define KID_END_MS        200
`define KID_ACK_MAX_MS    10
`define KID_TICKS_PER_MS  (`KID_CLK_HZ / 1000)
`define KID_WORD_BITS     28
`define KID_MODE_MSB      27
`define KID_MODE_LSB      24
`define KID_SERIAL_MSB    23
`define KID_HALF_BITS     14
`endif

// [hw/kid_link_if.sv]
// Pins of the key ID link between the core and the link-clock engine.
// Assumes both sides are instantiated by the top module.
`timescale 1ns/10ps
interface kid_link_if;
  logic key_valid_sync;
  logic bit_strobe;
  logic tx_data_hi;
  logic tx_data_lo;
  logic serial_bit_line;
  logic bit_ack_line;
  modport engine (output key_valid_sync, bit_strobe, tx_data_hi, tx_data_lo, serial_bit_line, bit_ack_line);
  modport top    (input  key_valid_sync, bit_strobe, tx_data_hi, tx_data_lo, serial_bit_line, bit_ack_line);
endinterface

// [hw/kid_pkg.sv]
// Types shared by the key ID download block.
// No assumptions beyond a SystemVerilog compiler.
package kid_pkg;
  typedef enum logic [1:0] {
    KID_COMM_TX   = 2'b00,
    KID_COMM_HS   = 2'b01,
    KID_COMM_ADV  = 2'b10
  } kid_comm_t;
endpackage

// [hw/kid_sync2.sv]
// Two-flip-flop level synchroniser into the clock domain of clk.
// Assumes the input is a slow level from another domain or a pin.
`timescale 1ns/10ps
module kid_sync2 #(
  parameter int W = 1
)(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// [hw/kid_top.sv]
// Key ID serial download from the selector switch to a process controller.
// Assumes mclk at 50 MHz; the link logic runs on link_clk and pins are async.
// How it works
// - Comm mode latched once after reset release
// - Word is key mode over serial number
// - Sync low without key, 100 ms pulse
// - Strobe square wave, 100 ms, 50 percent
// - Data bits settle before strobe rising edge
// - Bits 27..14 on hi, 13..0 lo
// - Device compares echo at end of strobe high
// - Mismatch aborts, resyncs and retries download
// - Handshake sync high while key valid
// - Ack high only while data bit valid
// - Handshake bits sent MSB first, 27..0
// - Ack and data within 10 ms
// - Ack drops after request falls
// - Ack held 200 ms after final bit
// - Sync low when key removed
// - Advanced mode downloads like handshake; lock/confirm passed
`timescale 1ns/10ps
module kid_top
  import kid_pkg::*;
#(
  parameter int LINK_HZ = 31250000
)(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        link_clk,
  input  wire logic [1:0]  comm_code,
  input  wire logic        key_present,
  input  wire logic        key_valid,
  input  wire logic [3:0]  key_mode,
  input  wire logic [23:0] key_serial,
  input  wire logic        echo_data_hi,
  input  wire logic        echo_data_lo,
  input  wire logic        bit_request_line,
  input  wire logic        preselect_confirm,
  input  wire logic        mode_change_lock,
  output logic             key_valid_sync,
  output logic             bit_strobe,
  output logic             tx_data_hi,
  output logic             tx_data_lo,
  output logic             serial_bit_line,
  output logic             bit_ack_line,
  output logic             confirm_req,
  output logic             lock_active,
  output logic             id_done,
  output logic [1:0]       comm_mode
);
  `include "kid_cfg.svh"
  localparam int TPM        = LINK_HZ / 1000;
  localparam int SYNC_CYC   = `KID_SYNC_MS * TPM;
  localparam int HALF_CYC   = (`KID_STROBE_MS * TPM) / 2;
  localparam int END_CYC    = `KID_END_MS * TPM;
  localparam int CW         = $clog2(END_CYC + 1);

  typedef enum logic [2:0] {
    KID_IDLE  = 3'b000,
    KID_SYNC  = 3'b001,
    KID_LOW   = 3'b010,
    KID_HIGH  = 3'b011,
    KID_WAITR = 3'b100,
    KID_ACK   = 3'b101,
    KID_WEND  = 3'b110,
    KID_DONE  = 3'b111
  } kid_state_t;

  kid_link_if lnk ();

  ////////////////////////////////////////////////////////////////////////
  // Link-side synchronisers for pins and core-domain levels
  logic [31:0] s_in;
  logic [31:0] s_raw;
  assign s_raw = {key_present, key_valid, key_mode, key_serial, echo_data_hi, echo_data_lo};
  logic        comm_hs_l;
  logic [33:0] s_all;
  kid_sync2 #(.W(34)) u_sync (
    .clk  (link_clk),
    .rstn (rstn),
    .d    ({bit_request_line, comm_hs_l, s_raw}),
    .q    (s_all)
  );
  logic l_req;
  logic l_hs;
  assign l_req = s_all[33];
  assign l_hs  = s_all[32];
  assign s_in  = s_all[31:0];
  logic        l_keyok;
  logic [27:0] l_word;
  logic        l_echo_hi;
  logic        l_echo_lo;
  assign l_keyok   = s_in[31] & s_in[30];
  assign l_word    = s_in[29:2];   // Mode in 27..24, serial below
  assign l_echo_hi = s_in[1];
  assign l_echo_lo = s_in[0];

  ////////////////////////////////////////////////////////////////////////
  // Mode strap caught once after reset in the core domain
  logic       cap_done;
  logic [1:0] mode_q;
  logic [1:0] strap1;
  logic [1:0] strap2;
  logic [1:0] cap_wait;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      strap1 <= 2'h0;
      strap2 <= 2'h0;
    end
    else
    begin
      strap1 <= comm_code;
      strap2 <= strap1;
    end
  end
  // Capture waits until both strap stages hold post-reset samples;
  // later strap changes are ignored until the next reset
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cap_wait <= 2'h0;
      cap_done <= 1'b0;
      mode_q   <= 2'h0;
    end
    else
    begin
      cap_wait <= {cap_wait[0], 1'b1};
      if (cap_wait[1] && !cap_done)
      begin
        cap_done <= 1'b1;
        mode_q   <= (strap2 == 2'h3) ? KID_COMM_TX : strap2;
      end
    end
  end
  assign comm_mode = mode_q;
  // Advanced mode reuses the handshake engine
  assign comm_hs_l = (mode_q == KID_COMM_HS) || (mode_q == KID_COMM_ADV);

  ////////////////////////////////////////////////////////////////////////
  // Link engine
  kid_state_t st;
  logic [CW-1:0] cnt;
  logic [4:0]    idx;
  logic [27:0]   word;
  logic          o_sync;
  logic          o_strobe;
  logic          o_hi;
  logic          o_lo;
  logic          o_ser;
  logic          o_ack;
  logic          ok_word;
  logic          mism;
  logic          mism_last;

  // In a high half the echo carries the pair of the previous period;
  // the first period has nothing to compare yet
  assign mism = (idx > 5'd1) &&
    ((l_echo_hi != word[5'd29 - idx]) || (l_echo_lo != word[5'd15 - idx]));
  // After the final fall the echo carries the last pair itself
  assign mism_last = (l_echo_hi != word[14]) || (l_echo_lo != word[0]);

  always_ff @(posedge link_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= KID_IDLE; cnt <= '0; idx <= 5'h0; word <= 28'h0;
      o_sync <= 1'b0; o_strobe <= 1'b0; o_hi <= 1'b0; o_lo <= 1'b0;
      o_ser <= 1'b0; o_ack <= 1'b0; ok_word <= 1'b0;
    end
    else if (!l_keyok)
    begin
      // Removal or invalid key drops sync and restarts
      st <= KID_IDLE; o_sync <= 1'b0; o_strobe <= 1'b0; o_hi <= 1'b0;
      o_lo <= 1'b0; o_ack <= 1'b0; o_ser <= 1'b0; ok_word <= 1'b0;
    end
    else
    begin
      unique case (st)
        KID_IDLE:
        begin
          word <= l_word; idx <= 5'h0; cnt <= '0;
          if (l_hs)
          begin
            o_sync <= 1'b1; st <= KID_WAITR;
          end
          else if (!ok_word)
          begin
            o_sync <= 1'b1; st <= KID_SYNC;
          end
        end
        KID_SYNC:
          if (cnt == CW'(SYNC_CYC - 1))
          begin
            o_sync <= 1'b0; cnt <= '0; st <= KID_LOW;
            o_hi <= word[27]; o_lo <= word[13];
          end
          else cnt <= cnt + 1'b1;
        KID_LOW:
          if (cnt == CW'(HALF_CYC - 1))
          begin
            cnt <= '0;
            if (idx == 5'd14)
            begin
              ok_word <= !mism_last; st <= KID_IDLE; o_hi <= 1'b0; o_lo <= 1'b0;
            end
            else
            begin
              o_strobe <= 1'b1; st <= KID_HIGH; idx <= idx + 1'b1;
            end
          end
          else cnt <= cnt + 1'b1;
        KID_HIGH:
          if (mism && cnt == CW'(HALF_CYC - 1))
          begin
            o_strobe <= 1'b0; o_hi <= 1'b0; o_lo <= 1'b0;
            cnt <= '0; st <= KID_IDLE;
          end
          else if (cnt == CW'(HALF_CYC - 1))
          begin
            o_strobe <= 1'b0; cnt <= '0; st <= KID_LOW;
            if (idx != 5'd14)
            begin
              o_hi <= word[5'd27 - idx]; o_lo <= word[5'd13 - idx];
            end
          end
          else cnt <= cnt + 1'b1;
        KID_WAITR:
          if (l_req)
          begin
            o_ser <= word[5'd27 - idx];
            st <= KID_ACK;
          end
        KID_ACK:
        begin
          o_ack <= 1'b1;
          if (!l_req)
          begin
            if (idx == 5'd27)
            begin
              cnt <= '0; st <= KID_WEND;
            end
            else
            begin
              o_ack <= 1'b0; idx <= idx + 1'b1; st <= KID_WAITR;
            end
          end
        end
        KID_WEND:
          if (cnt == CW'(END_CYC - 1))
          begin
            o_ack <= 1'b0; st <= KID_DONE;
          end
          else cnt <= cnt + 1'b1;
        KID_DONE:
        begin
          // Next word only after the whole previous one
          idx <= 5'h0; word <= l_word; ok_word <= 1'b1; st <= KID_WAITR;
        end
        default: st <= KID_IDLE;
      endcase
    end
  end
  assign lnk.key_valid_sync  = o_sync;
  assign lnk.bit_strobe      = o_strobe;
  assign lnk.tx_data_hi      = o_hi;
  assign lnk.tx_data_lo      = o_lo;
  assign lnk.serial_bit_line = o_ser;
  assign lnk.bit_ack_line    = o_ack;
  assign key_valid_sync  = lnk.key_valid_sync;
  assign bit_strobe      = lnk.bit_strobe;
  assign tx_data_hi      = lnk.tx_data_hi;
  assign tx_data_lo      = lnk.tx_data_lo;
  assign serial_bit_line = lnk.serial_bit_line;
  assign bit_ack_line    = lnk.bit_ack_line;

  ////////////////////////////////////////////////////////////////////////
  // Core-domain status: completion level and controller inputs
  logic [2:0] c_q;
  kid_sync2 #(.W(3)) u_csync (
    .clk  (mclk),
    .rstn (rstn),
    .d    ({ok_word, preselect_confirm, mode_change_lock}),
    .q    (c_q)
  );
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      id_done <= 1'b0; confirm_req <= 1'b0; lock_active <= 1'b0;
    end
    else
    begin
      id_done     <= c_q[2];
      // Only meaningful in advanced mode; lock is active on a low input
      confirm_req <= (mode_q == KID_COMM_ADV) & c_q[1];
      lock_active <= (mode_q == KID_COMM_ADV) & ~c_q[0];
    end
  end
endmodule

// [tb/kid_chk.sv]
// Port assertions for the key ID download block.
// Bound into kid_top; counts follow its LINK_HZ.
`timescale 1ns/10ps
module kid_chk #(
  parameter int LINK_HZ = 31250000
)(
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       link_clk,
  input wire logic       key_present,
  input wire logic       key_valid,
  input wire logic       bit_request_line,
  input wire logic       key_valid_sync,
  input wire logic       bit_strobe,
  input wire logic       tx_data_hi,
  input wire logic       tx_data_lo,
  input wire logic       bit_ack_line,
  input wire logic       confirm_req,
  input wire logic       lock_active,
  input wire logic [1:0] comm_mode
);
  localparam int HALF = LINK_HZ / 20;
  localparam int SYNC = LINK_HZ / 10;
  localparam int ACKW = LINK_HZ / 100;
  int hi_n;
  int sy_n;
  int m_n;
  ////////////////////////////////////////
  // High-run lengths, judged at the falling edge
  always_ff @(posedge link_clk or negedge rstn)
    if (!rstn) hi_n <= 0;
    else hi_n <= bit_strobe ? hi_n + 1 : 0;
  always_ff @(posedge link_clk or negedge rstn)
    if (!rstn) sy_n <= 0;
    else sy_n <= key_valid_sync ? sy_n + 1 : 0;
  // Mode may settle only in the first core cycles
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) m_n <= 0;
    else if (m_n < 15) m_n <= m_n + 1;
  ////////////////////////////////////////
  a_sync_nokey: assert property (@(posedge link_clk) disable iff (!rstn)
    !key_present [*4] |-> !key_valid_sync) else $error("sync high without key");
  a_sync_pulse: assert property (@(posedge link_clk) disable iff (!rstn)
    $fell(key_valid_sync) && comm_mode == 2'h0 && key_present && key_valid |-> sy_n == SYNC)
    else $error("sync pulse length wrong");
  // An echo abort still runs the high half in full; a fresh sync after the fall also passes
  a_strobe_half: assert property (@(posedge link_clk) disable iff (!rstn)
    $fell(bit_strobe) && key_present && key_valid |-> (hi_n == HALF) or (##[1:3] key_valid_sync))
    else $error("strobe high half wrong");
  a_data_stable: assert property (@(posedge link_clk) disable iff (!rstn)
    comm_mode == 2'h0 && bit_strobe |-> $stable(tx_data_hi) && $stable(tx_data_lo))
    else $error("tx data moved while strobe high");
  a_ack_req: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(bit_request_line) && key_valid_sync && !bit_ack_line |-> ##[1:ACKW] bit_ack_line)
    else $error("ack late");
  a_ack_cause: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(bit_ack_line) |-> bit_request_line) else $error("ack without request");
  a_mode_held: assert property (@(posedge mclk) disable iff (!rstn)
    m_n == 15 |-> $stable(comm_mode)) else $error("mode changed while powered");
  a_adv_only: assert property (@(posedge mclk) disable iff (!rstn)
    comm_mode != 2'h2 |-> !confirm_req && !lock_active) else $error("advanced outputs outside mode");
endmodule
bind kid_top kid_chk #(.LINK_HZ(LINK_HZ)) u_chk (.*);

// [tb/kid_ctl.sv]
// Behavioural process controller on the far side of the key ID link.
// Paced by link_clk; times assume LINK_HZ of 1000, one cycle per ms.
`timescale 1ns/10ps
module kid_ctl (
  input  wire logic link_clk,
  input  wire logic key_valid_sync,
  input  wire logic bit_strobe,
  input  wire logic tx_data_hi,
  input  wire logic tx_data_lo,
  input  wire logic serial_bit_line,
  input  wire logic bit_ack_line,
  output logic      echo_data_hi,
  output logic      echo_data_lo,
  output logic      bit_request_line
);
  logic [27:0] got;
  logic [1:0]  last;
  logic [1:0]  prev;
  logic        bad = 0;
  int          n;
  initial {echo_data_hi, echo_data_lo, bit_request_line} = 3'h0;
  always @(posedge key_valid_sync) n = 0;
  // Read at the strobe rise, echo the pair read one period earlier
  always @(posedge bit_strobe)
    if (n < 14)
    begin
      prev = last;
      last = {tx_data_hi, tx_data_lo};
      got[27 - n] = tx_data_hi;
      got[13 - n] = tx_data_lo;
      n++;
      @(posedge link_clk) #2;
      {echo_data_hi, echo_data_lo} = n > 1 ? prev ^ {bad, 1'b0} : 2'h0;
      if (n > 1) bad = 0;
    end
  // Final pair held 80 ms, inside the 60 to 100 ms window
  always @(negedge bit_strobe)
    if (n == 14)
    begin
      @(posedge link_clk) #2 {echo_data_hi, echo_data_lo} = last;
      repeat (80) @(posedge link_clk);
      #2 {echo_data_hi, echo_data_lo} = 2'h0;
    end
  task automatic hs_word(output logic [27:0] w, output int hold, output logic tmo);
    int t;
    tmo = 0;
    hold = 0;
    for (int i = 27; i >= 0; i--)
    begin
      @(posedge link_clk) #2 bit_request_line = 1;
      for (t = 0; t < 20 && bit_ack_line !== 1'b1; t++) @(posedge link_clk) #2;
      if (t == 20) tmo = 1;
      w[i] = serial_bit_line;
      @(posedge link_clk) #2 bit_request_line = 0;
      for (t = 0; t < 400 && bit_ack_line === 1'b1; t++) @(posedge link_clk) #2;
      if (i > 0 && t > 10) tmo = 1;
      hold = t;
    end
  endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the key ID download block.
// Each comm mode runs from its own reset with a random key word.
`timescale 1ns/10ps
module tb;
  localparam int LHZ = 1000;
  localparam int END = LHZ / 5;
  logic        mclk = 0, link_clk = 0, rstn = 0, key_present = 0, key_valid = 0;
  logic        preselect_confirm = 0, mode_change_lock = 0;
  logic [1:0]  comm_code = 0;
  logic [3:0]  key_mode = 0;
  logic [23:0] key_serial = 0;
  logic        echo_data_hi, echo_data_lo, bit_request_line, key_valid_sync, bit_strobe, tx_data_hi;
  logic        tx_data_lo, serial_bit_line, bit_ack_line, confirm_req, lock_active, id_done;
  logic [1:0]  comm_mode;
  int          n_fail = 0, num_checks = 0, n_sync = 0;
  always #10 mclk = ~mclk;
  always #16 link_clk = ~link_clk;
  always @(posedge key_valid_sync) n_sync++;
  kid_top #(.LINK_HZ(LHZ)) dut (.*);
  kid_ctl ctl (.*);
  ////////////////////////////////////////
  function automatic logic [27:0] word_of(input logic [3:0] m, input logic [23:0] s);
    return {m, s};
  endfunction
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    int t;
    for (t = 0; t < lim && s !== 1'b1; t++) @(posedge mclk);
    if (t == lim) n_fail++;
    if (t == lim) test_done();
  endtask
  task automatic keys(input logic p, input logic v);
    @(posedge mclk) #2;
    key_present = p;
    key_valid = v;
    repeat (12) @(posedge mclk);
  endtask
  // Strap moves after release; the latched mode must not follow
  task automatic start(input logic [1:0] m);
    @(posedge mclk) #2;
    rstn = 0;
    comm_code = m;
    {key_mode, key_serial} = 28'($urandom);
    n_sync = 0;
    repeat (12) @(posedge mclk);
    #2 rstn = 1;
    repeat (20) @(posedge mclk);
    #2 comm_code = ~m;
    chk(comm_mode, m);
  endtask
  task automatic hs;
    logic [27:0] w;
    int          hold;
    logic        tmo;
    ctl.hs_word(w, hold, tmo);
    chk(w, word_of(key_mode, key_serial));
    chk(hold >= END && hold <= END + 8, 1);
    chk(tmo, 0);
    if (tmo !== 1'b0) test_done();
  endtask
  ////////////////////////////////////////
  initial
  begin
    void'($urandom(59704));
    start(2'h0);
    ctl.bad = 1;
    keys(1, 1);
    wait_hi(id_done, 8000);
    chk(n_sync, 2);
    chk(ctl.got, word_of(key_mode, key_serial));
    keys(0, 1);
    chk(key_valid_sync, 0);
    chk(comm_mode, 2'h0);
    start(2'h1);
    keys(1, 1);
    chk(key_valid_sync, 1);
    repeat (2) hs();
    keys(1, 0);
    chk(key_valid_sync, 0);
    start(2'h2);
    keys(1, 1);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk) #2;
      {preselect_confirm, mode_change_lock} = 2'(i);
      repeat (12) @(posedge mclk);
      chk(confirm_req, preselect_confirm);
      chk(lock_active, !mode_change_lock);
    end
    hs();
    repeat (8) @(posedge mclk);
    chk(id_done, 1);
    keys(0, 1);
    chk(key_valid_sync, 0);
    chk(id_done, 0);
    test_done();
  end
endmodule
